// ==== nco_pkg.sv ====
/*
 holds register offsets, field positions, reset values and encodings
 shared by the numerically controlled oscillator block.
 assumes byte-wide registers reached over a plain strobe port.
*/
package nco_pkg;
    // register offsets on the plain port
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_CLOCK_SELECT = 4'h1;
    localparam logic [3:0] OFS_ACC_LOW = 4'h2;
    localparam logic [3:0] OFS_ACC_HIGH = 4'h3;
    localparam logic [3:0] OFS_ACC_UPPER = 4'h4;
    localparam logic [3:0] OFS_INC_LOW = 4'h5;
    localparam logic [3:0] OFS_INC_HIGH = 4'h6;
    localparam logic [3:0] OFS_IRQ = 4'h7;
    localparam int ADDR_W = 4;
    // control register bit positions
    localparam int CTL_PFM = 0;
    localparam int CTL_POL = 4;
    localparam int CTL_OUT = 5;
    localparam int CTL_OE = 6;
    localparam int CTL_EN = 7;
    // clock select fields
    localparam int CLK_PWS_LO = 5;
    localparam int CLK_CKS_LO = 0;
    // irq register bits: flag, module enable, peripheral, global
    localparam int IRQ_FLAG = 0;
    localparam int IRQ_IE = 1;
    localparam int IRQ_PERIPHERAL_IRQ_ENABLE = 2;
    localparam int IRQ_GIE = 3;
    // widths and reset values
    localparam int ACC_W = 20;
    localparam int INC_W = 16;
    localparam logic [7:0] INC_LOW_RESET = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] CTL_WMASK = 8'hD1;
    localparam logic [7:0] CLK_WMASK = 8'hE3;
    localparam logic [7:0] IRQ_WMASK = 8'h0F;
    localparam logic [1:0] LOAD_EDGES = 2'h2;
    // clock source encodings
    typedef enum logic [1:0]
    {
        SRC_FAST_OSC = 2'b00,
        SRC_SYSTEM = 2'b01,
        SRC_LOGIC_CELL = 2'b10,
        SRC_EXT_PIN = 2'b11
    } clk_src_type;
endpackage : nco_pkg

// ==== numeric_osc_divider.sv ====
/*
 numerically controlled oscillator: 20-bit phase accumulator, buffered
 16-bit step, fixed duty and pulse modes, polarity, pin enable, flag.
 assumes all clock sources arrive as asynchronous levels, sampled on mclk;
 a source edge is one mclk-wide tick. sources must be below mclk/4.
*/
// Chosen here: the strobed register port and the placing of the registers.
// Operation
// - add buffered step each module clock edge
// - accumulator as three bytes, upper nibble zero
// - enabled: buffer loads second edge after low write
// - disabled: buffer loads right after step write
// - fixed duty mode toggles on each overflow
// - control bit 0 selects pulse mode
// - pulse mode: active for selected periods
// - pulse starts on edge after overflow
// - width field gives two-power periods
// - width only in pulse mode
// - clock field selects one of four sources
// - control bit 4 inverts final output
// - polarity change raises flag for transition
// - control bit 5 reads output level
// - control bit 6 drives output pin while bit 7 enables
// - bit 7 enables; bits 3..1 read zero
// - flag on overflow; forwarded when all enabled
// - reset clears all, step low bit one
// - runs from its own selected source
// - keep fast oscillator on when enabled and selected
// - polarity-adjusted output to peripherals
`timescale 1ns/1ns
module numeric_osc_divider
    import nco_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [nco_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic internal_fast_oscillator,
    input wire logic system_clock_in,
    input wire logic logic_cell_one_output,
    input wire logic ext_clock_pin,
    output logic nco_out,
    output logic nco_pin_out,
    output logic nco_pin_oe,
    output logic overflow_irq,
    output logic keep_fast_osc_on
);
    import nco_pkg::*;

    // two-flop synchronisers, one per source
    logic [3:0] src_meta_ff;
    logic [3:0] src_sync_ff;
    logic [3:0] src_prev_ff;
    logic [3:0] nxt_src_meta;
    logic [3:0] nxt_src_sync;
    logic [3:0] nxt_src_prev;
    // registers
    logic [7:0] control_ff, nxt_control;
    logic [7:0] clk_sel_ff, nxt_clk_sel;
    logic [ACC_W-1:0] phase_accumulator_ff, nxt_phase_accumulator;
    logic [7:0] inc_low_ff, nxt_inc_low;
    logic [7:0] step_value_high_ff, nxt_step_value_high;
    logic [INC_W-1:0] step_buf_ff, nxt_step_buf;
    logic [1:0] load_cnt_ff, nxt_load_cnt;   // edges left before load
    logic load_pend_ff, nxt_load_pend;
    logic [3:0] irq_ff, nxt_irq;
    logic raw_ff, nxt_raw;                  // pre-polarity level
    logic [7:0] pulse_cnt_ff, nxt_pulse_cnt;
    logic [7:0] rdata_ff, nxt_rdata;
    logic out_ff, nxt_out;
    logic pin_ff, nxt_pin;
    logic oe_ff, nxt_oe;
    logic irq_out_ff, nxt_irq_out;
    logic fast_on_ff, nxt_fast_on;

    // decoded helpers
    logic module_enable;
    logic pulse_mode_select;
    logic output_invert;
    logic module_clock;                     // one-cycle tick of source
    logic [ACC_W:0] sum;
    logic accumulator_carry;
    logic [7:0] pulse_len;
    logic wr_ctl, wr_inc_low, wr_inc_high;

    // register write decode, shared by several paths
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] ofs,
                                 input logic stb);
        hit = stb && (a == ofs);
    endfunction : hit

    // synchroniser: first flop feeds only the second
    always_comb
    begin
        nxt_src_meta = {ext_clock_pin, logic_cell_one_output,
                        system_clock_in, internal_fast_oscillator};
        nxt_src_sync = src_meta_ff;
        nxt_src_prev = src_sync_ff;
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            src_meta_ff <= 4'h0;
            src_sync_ff <= 4'h0;
            src_prev_ff <= 4'h0;
        end
        else if (clk_en)
        begin
            src_meta_ff <= nxt_src_meta;
            src_sync_ff <= nxt_src_sync;
            src_prev_ff <= nxt_src_prev;
        end
    end

    // datapath and register next-state
    always_comb
    begin
        module_enable = control_ff[CTL_EN];
        pulse_mode_select = control_ff[CTL_PFM];
        output_invert = control_ff[CTL_POL];
        // rising-edge tick of the selected source
        module_clock = src_sync_ff[clk_sel_ff[CLK_CKS_LO +: 2]] &&
                       !src_prev_ff[clk_sel_ff[CLK_CKS_LO +: 2]];
        sum = {1'b0, phase_accumulator_ff} +
              {{(ACC_W - INC_W + 1){1'b0}}, step_buf_ff};
        accumulator_carry = module_enable && module_clock && sum[ACC_W];
        pulse_len = 8'h01 << clk_sel_ff[CLK_PWS_LO +: 3];
        wr_ctl = hit(reg_addr, OFS_CONTROL, reg_wr);
        wr_inc_low = hit(reg_addr, OFS_INC_LOW, reg_wr);
        wr_inc_high = hit(reg_addr, OFS_INC_HIGH, reg_wr);

        nxt_control = control_ff;
        nxt_clk_sel = clk_sel_ff;
        nxt_phase_accumulator = phase_accumulator_ff;
        nxt_inc_low = inc_low_ff;
        nxt_step_value_high = step_value_high_ff;
        nxt_step_buf = step_buf_ff;
        nxt_load_cnt = load_cnt_ff;
        nxt_load_pend = load_pend_ff;
        nxt_irq = irq_ff;
        nxt_raw = raw_ff;
        nxt_pulse_cnt = pulse_cnt_ff;

        // accumulator runs only while enabled
        if (module_enable && module_clock)
        begin
            nxt_phase_accumulator = sum[ACC_W-1:0];
        end

        // output shaping on overflow
        if (pulse_mode_select)
        begin
            // pulse counter counts module clock periods
            if (accumulator_carry)
            begin
                nxt_raw = 1'b1;
                nxt_pulse_cnt = pulse_len;
            end
            else if (raw_ff && module_clock)
            begin
                nxt_pulse_cnt = pulse_cnt_ff - 8'h01;
                if (pulse_cnt_ff <= 8'h01)
                begin
                    nxt_raw = 1'b0;
                end
            end
        end
        else if (accumulator_carry)
        begin
            nxt_raw = !raw_ff;
        end

        // polarity write that flips the output also flags
        if (accumulator_carry ||
            (wr_ctl && (reg_wdata[CTL_POL] != output_invert)))
        begin
            nxt_irq[IRQ_FLAG] = 1'b1;
        end
        else if (hit(reg_addr, OFS_IRQ, reg_wr))
        begin
            // set beats clear: clear only when no event
            nxt_irq[IRQ_FLAG] = reg_wdata[IRQ_FLAG];
        end
        if (hit(reg_addr, OFS_IRQ, reg_wr))
        begin
            nxt_irq[IRQ_GIE:IRQ_IE] = reg_wdata[IRQ_GIE:IRQ_IE];
        end

        // increment buffer: count two module edges after low write
        if (load_pend_ff && module_clock)
        begin
            nxt_load_cnt = load_cnt_ff - 2'h1;
            if (load_cnt_ff == 2'h1)
            begin
                nxt_step_buf = {step_value_high_ff, inc_low_ff};
                nxt_load_pend = 1'b0;
            end
        end

        // register writes
        if (wr_ctl)
        begin
            nxt_control = (reg_wdata & CTL_WMASK) | (control_ff & ~CTL_WMASK);
        end
        if (hit(reg_addr, OFS_CLOCK_SELECT, reg_wr))
        begin
            nxt_clk_sel = reg_wdata & CLK_WMASK;
        end
        if (hit(reg_addr, OFS_ACC_LOW, reg_wr))
        begin
            nxt_phase_accumulator[7:0] = reg_wdata;
        end
        if (hit(reg_addr, OFS_ACC_HIGH, reg_wr))
        begin
            nxt_phase_accumulator[15:8] = reg_wdata;
        end
        if (hit(reg_addr, OFS_ACC_UPPER, reg_wr))
        begin
            nxt_phase_accumulator[ACC_W-1:16] = reg_wdata[3:0];
        end
        if (wr_inc_high)
        begin
            nxt_step_value_high = reg_wdata;
            if (!module_enable)
            begin
                nxt_step_buf = {reg_wdata, inc_low_ff};
            end
        end
        if (wr_inc_low)
        begin
            nxt_inc_low = reg_wdata;
            if (!module_enable)
            begin
                nxt_step_buf = {step_value_high_ff, reg_wdata};
            end
            else
            begin
                // high byte must already be in place
                nxt_load_pend = 1'b1;
                nxt_load_cnt = LOAD_EDGES;
            end
        end
        // status bit mirrors the live output level
        nxt_control[CTL_OUT] = nxt_raw ^ nxt_control[CTL_POL];

        // read mux, data valid the cycle after
        nxt_rdata = BYTE_ZERO;
        if (reg_rd)
        begin
            unique case (reg_addr)
                OFS_CONTROL: nxt_rdata = control_ff;
                OFS_CLOCK_SELECT: nxt_rdata = clk_sel_ff;
                OFS_ACC_LOW: nxt_rdata = phase_accumulator_ff[7:0];
                OFS_ACC_HIGH: nxt_rdata = phase_accumulator_ff[15:8];
                OFS_ACC_UPPER: nxt_rdata = {4'h0,
                    phase_accumulator_ff[ACC_W-1:16]};
                OFS_INC_LOW: nxt_rdata = inc_low_ff;
                OFS_INC_HIGH: nxt_rdata = step_value_high_ff;
                OFS_IRQ: nxt_rdata = {4'h0, irq_ff};
                default: nxt_rdata = BYTE_ZERO;            // unmapped
            endcase
        end

        // outputs, all registered
        nxt_out = nxt_control[CTL_OUT];
        nxt_pin = nxt_control[CTL_OUT];
        nxt_oe = nxt_control[CTL_OE] && nxt_control[CTL_EN];
        nxt_irq_out = nxt_irq[IRQ_FLAG] && nxt_control[CTL_EN] &&
                      nxt_irq[IRQ_IE] && nxt_irq[IRQ_PERIPHERAL_IRQ_ENABLE] &&
                      nxt_irq[IRQ_GIE];
        nxt_fast_on = nxt_control[CTL_EN] &&
            (nxt_clk_sel[CLK_CKS_LO +: 2] == SRC_FAST_OSC);
    end

    // state registers; reset clears all, step low bit to one
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            control_ff <= BYTE_ZERO;
            clk_sel_ff <= BYTE_ZERO;
            phase_accumulator_ff <= '0;
            inc_low_ff <= INC_LOW_RESET;
            step_value_high_ff <= BYTE_ZERO;
            step_buf_ff <= {BYTE_ZERO, INC_LOW_RESET};
            load_cnt_ff <= 2'h0;
            load_pend_ff <= 1'b0;
            irq_ff <= 4'h0;
            raw_ff <= 1'b0;
            pulse_cnt_ff <= BYTE_ZERO;
            rdata_ff <= BYTE_ZERO;
            out_ff <= 1'b0;
            pin_ff <= 1'b0;
            oe_ff <= 1'b0;
            irq_out_ff <= 1'b0;
            fast_on_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            control_ff <= nxt_control;
            clk_sel_ff <= nxt_clk_sel;
            phase_accumulator_ff <= nxt_phase_accumulator;
            inc_low_ff <= nxt_inc_low;
            step_value_high_ff <= nxt_step_value_high;
            step_buf_ff <= nxt_step_buf;
            load_cnt_ff <= nxt_load_cnt;
            load_pend_ff <= nxt_load_pend;
            irq_ff <= nxt_irq;
            raw_ff <= nxt_raw;
            pulse_cnt_ff <= nxt_pulse_cnt;
            rdata_ff <= nxt_rdata;
            out_ff <= nxt_out;
            pin_ff <= nxt_pin;
            oe_ff <= nxt_oe;
            irq_out_ff <= nxt_irq_out;
            fast_on_ff <= nxt_fast_on;
        end
    end

    assign reg_rdata = rdata_ff;
    assign nco_out = out_ff;
    assign nco_pin_out = pin_ff;
    assign nco_pin_oe = oe_ff;
    assign overflow_irq = irq_out_ff;
    assign keep_fast_osc_on = fast_on_ff;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    overflow_sets_flag_a: assert property (clk_en && accumulator_carry
        |=> irq_ff[IRQ_FLAG])
        else $error("overflow did not set flag");
    acc_adds_step_a: assert property (clk_en && module_enable &&
        module_clock && !reg_wr |=> phase_accumulator_ff ==
        $past(sum[ACC_W-1:0]))
        else $error("accumulator did not add step");
    fdc_toggle_a: assert property (clk_en && !pulse_mode_select &&
        accumulator_carry && !reg_wr |=> raw_ff != $past(raw_ff))
        else $error("fixed duty did not toggle");
    pulse_start_a: assert property (clk_en && pulse_mode_select &&
        accumulator_carry && !reg_wr |=> raw_ff)
        else $error("pulse did not start");
    upper_zero_a: assert property (clk_en && reg_rd &&
        reg_addr == OFS_ACC_UPPER |=> reg_rdata[7:4] == 4'h0)
        else $error("upper nibble not zero");
    ctl_unused_a: assert property (clk_en && reg_rd &&
        reg_addr == OFS_CONTROL |=> reg_rdata[3:1] == 3'h0)
        else $error("control bits 3..1 not zero");
    out_level_a: assert property (clk_en |=> nco_out ==
        (raw_ff ^ control_ff[CTL_POL]))
        else $error("output polarity wrong");
    oe_follow_a: assert property (clk_en && !reg_wr |=> nco_pin_oe ==
        (control_ff[CTL_OE] && control_ff[CTL_EN]))
        else $error("pin enable wrong");
    irq_gate_a: assert property (!control_ff[CTL_EN] && clk_en && !reg_wr
        |=> !overflow_irq)
        else $error("interrupt while disabled");
    disabled_load_a: assert property (clk_en && wr_inc_low &&
        !module_enable |=> step_buf_ff[7:0] == $past(reg_wdata))
        else $error("step buffer not loaded");

    pulse_seen_c: cover property (pulse_mode_select && accumulator_carry);
    fdc_seen_c: cover property (!pulse_mode_select && accumulator_carry);
    irq_seen_c: cover property (overflow_irq);
    buffered_load_c: cover property (load_pend_ff ##1 !load_pend_ff);
endmodule : numeric_osc_divider

// ==== nco_source_model.sv ====
/*
 far-side model: makes the four clock sources in counted bursts and
 resolves the output pin level from the block's data and enable.
 assumes mclk at 125 MHz and a synchronous active-low reset.
*/
`timescale 1ns/1ns
module nco_source_model
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [3:0] src_mask,
    input wire logic burst_go,
    input wire logic [7:0] burst_len,
    output logic busy,
    output logic [3:0] src_level,
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_level
);
    logic [3:0] phase_ff; // place inside one source period
    logic [7:0] left_ff; // source edges still to make
    logic last_ff; // last value the block drove
    // one period is 16 mclk, well below the sampler's limit of mclk/4
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            phase_ff <= 4'h0;
            left_ff <= 8'h00;
            last_ff <= 1'b0;
        end
        else
        begin
            if (pin_oe)
                last_ff <= pin_out;
            if (burst_go && !busy)
            begin
                left_ff <= burst_len;
                phase_ff <= 4'h0;
            end
            else if (busy)
            begin
                phase_ff <= phase_ff + 4'h1;
                if (phase_ff == 4'hF)
                    left_ff <= left_ff - 8'h01;
            end
        end
    end
    assign busy = (left_ff != 8'h00);
    // sources stand low between bursts; masked ones never move
    assign src_level = (busy && !phase_ff[3]) ? src_mask : 4'h0;
    // an undriven pin shows the inverse, so a stale value cannot pass
    assign pin_level = pin_oe ? pin_out : ~last_ff;
endmodule : nco_source_model

// ==== test_numeric_osc_divider.sv ====
/*
 self-checking bench for the oscillator block: register access over the
 strobe port, counted source bursts from the far-side model, port checks.
 assumes the offsets and field positions of the shared package.
*/
`timescale 1ns/1ns
module test_numeric_osc_divider;
    import nco_pkg::*;
    logic mclk, rst_n, clk_en, reg_wr, reg_rd, busy, burst_go;
    logic [ADDR_W-1:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, burst_len;
    logic [3:0] src_mask, src_level;
    logic nco_out, nco_pin_out, nco_pin_oe, overflow_irq, keep_fast_osc_on;
    logic pin_level;
    int err_total = 0;
    int total_checks = 0;
    logic [7:0] rst_exp [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01,
                                8'h00, 8'h00}; // reset image of offsets 0..7
    numeric_osc_divider u_numeric_osc_divider (.mclk(mclk), .rst_n(rst_n),
        .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .internal_fast_oscillator(src_level[0]),
        .system_clock_in(src_level[1]), .logic_cell_one_output(src_level[2]),
        .ext_clock_pin(src_level[3]), .nco_out(nco_out),
        .nco_pin_out(nco_pin_out), .nco_pin_oe(nco_pin_oe),
        .overflow_irq(overflow_irq), .keep_fast_osc_on(keep_fast_osc_on));
    nco_source_model u_nco_source_model (.mclk(mclk), .rst_n(rst_n),
        .src_mask(src_mask), .burst_go(burst_go), .burst_len(burst_len),
        .busy(busy), .src_level(src_level), .pin_out(nco_pin_out),
        .pin_oe(nco_pin_oe), .pin_level(pin_level));
    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // verdict and the end of the run, reached from every path
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one-cycle write strobe beside address and data
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 check($sformatf("reg %h", a), reg_rdata, e);
    endtask : rd_chk
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle
    task automatic set_acc(input logic [19:0] v);
        wr(OFS_ACC_LOW, v[7:0]);
        wr(OFS_ACC_HIGH, v[15:8]);
        wr(OFS_ACC_UPPER, {4'h0, v[19:16]});
    endtask : set_acc
    // counted source edges, then eight cycles of room for the sampler delay
    task automatic burst(input logic [3:0] m, input logic [7:0] n);
        int i;
        src_mask <= m;
        @(posedge mclk);
        burst_go <= 1'b1;
        burst_len <= n;
        @(posedge mclk);
        burst_go <= 1'b0;
        // look after the model has taken the start, not in the same step
        #1;
        for (i = 0; i < 5000 && busy === 1'b1; i++)
            settle(1);
        if (i == 5000)
        begin
            err_total++;
            test_done();
        end
        settle(8);
    endtask : burst
    initial
    begin
        {reg_wr, reg_rd, burst_go} = 3'b000;
        {reg_addr, reg_wdata, burst_len, src_mask} = '0;
        clk_en = 1'b1;
        rst_n = 1'b0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        // reset image, unmapped place, read-only and reserved bits
        for (int i = 0; i < 8; i++)
            rd_chk(i[ADDR_W-1:0], rst_exp[i]);
        wr(4'h9, 8'hFF);
        rd_chk(4'h9, 8'h00);
        wr(OFS_CONTROL, 8'h6E);
        rd_chk(OFS_CONTROL, 8'h40);
        settle(3);
        check("pin oe off", nco_pin_oe, 8'h00);
        wr(OFS_CLOCK_SELECT, 8'hFF);
        rd_chk(OFS_CLOCK_SELECT, 8'hE3);
        // a write taken while the clock enable is low must not land
        clk_en <= 1'b0;
        wr(OFS_CLOCK_SELECT, 8'h00);
        clk_en <= 1'b1;
        rd_chk(OFS_CLOCK_SELECT, 8'hE3);
        set_acc(20'hFFFFF);
        rd_chk(OFS_ACC_UPPER, 8'h0F);
        // disabled: no counting, step byte writes load at once
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_CLOCK_SELECT, 8'h01);
        wr(OFS_INC_HIGH, 8'h00);
        wr(OFS_INC_LOW, 8'h10);
        set_acc(20'h00000);
        burst(4'hF, 8'd2);
        rd_chk(OFS_ACC_LOW, 8'h00);
        wr(OFS_CONTROL, 8'hC0);
        burst(4'hF, 8'd5);
        rd_chk(OFS_ACC_LOW, 8'h50);
        check("pin oe on", nco_pin_oe, 8'h01);
        // fixed duty: carry toggles the output and sets the flag
        set_acc(20'hFFFF0);
        burst(4'hF, 8'd1);
        check("fdc out", nco_out, 8'h01);
        check("pin", pin_level, 8'h01);
        rd_chk(OFS_ACC_HIGH, 8'h00);
        rd_chk(OFS_CONTROL, 8'hE0);
        rd_chk(OFS_IRQ, 8'h01);
        // forwarding needs every enable; the flag stays until cleared
        foreach (rst_exp[i])
        begin
            if (i < 3)
            begin
                wr(OFS_IRQ, 8'h0F ^ (8'h02 << i));
                settle(3);
                check("irq gated", overflow_irq, 8'h00);
            end
        end
        wr(OFS_IRQ, 8'h0F);
        settle(30);
        check("irq on", overflow_irq, 8'h01);
        wr(OFS_IRQ, 8'h0E);
        rd_chk(OFS_IRQ, 8'h0E);
        check("irq off", overflow_irq, 8'h00);
        // polarity change flips the output and raises the flag
        wr(OFS_CONTROL, 8'hD0);
        settle(3);
        check("inverted", nco_out, 8'h00);
        check("pol irq", overflow_irq, 8'h01);
        wr(OFS_IRQ, 8'h00);
        wr(OFS_CONTROL, 8'h80);
        wr(OFS_IRQ, 8'h00);
        // each source advances the sum alone; fast source kept on only while selected
        for (int s = 0; s < 4; s++)
        begin
            wr(OFS_CLOCK_SELECT, s[7:0]);
            set_acc(20'h00000);
            burst(~(4'h1 << s), 8'd2);
            rd_chk(OFS_ACC_LOW, 8'h00);
            burst(4'h1 << s, 8'd2);
            rd_chk(OFS_ACC_LOW, 8'h20);
            check("keep osc", keep_fast_osc_on, {7'h00, s == 0});
        end
        // enabled: new step loads on the second tick after the write, first adds on the third
        wr(OFS_INC_HIGH, 8'h01);
        wr(OFS_INC_LOW, 8'h00);
        set_acc(20'h00000);
        burst(4'hF, 8'd1);
        rd_chk(OFS_ACC_LOW, 8'h10);
        burst(4'hF, 8'd2);
        rd_chk(OFS_ACC_LOW, 8'h20);
        rd_chk(OFS_ACC_HIGH, 8'h01);
        // pulse mode: active for two to the field value ticks
        wr(OFS_CONTROL, 8'h81);
        for (int p = 0; p < 8; p++)
        begin
            wr(OFS_CLOCK_SELECT, {p[2:0], 5'h01});
            set_acc(20'hFFFF0);
            burst(4'hF, 8'd1);
            check("pulse start", nco_out, 8'h01);
            if (p > 0)
                burst(4'hF, (8'h01 << p) - 8'h01);
            check("pulse hold", nco_out, 8'h01);
            burst(4'hF, 8'd1);
            check("pulse end", nco_out, 8'h00);
        end
        test_done();
    end
endmodule : test_numeric_osc_divider
